/* File: crtif_cfg.svh */
// Offsets, field positions, reset values and timing counts of the crate trigger interface
`ifndef CRTIF_CFG_SVH
`define CRTIF_CFG_SVH

// ==========================================================
// Register byte offsets
`define CRTIF_A_CTRL 8'h00
`define CRTIF_A_TXEN 8'h04
`define CRTIF_A_STAT 8'h08
`define CRTIF_A_TIME 8'h0c
`define CRTIF_A_EVHI 8'h10
`define CRTIF_A_EVLO 8'h14
`define CRTIF_A_EVCNT 8'h18

// ==========================================================
// Field positions
`define CRTIF_CTRL_SRCB 0
`define CRTIF_CTRL_GEN 1
`define CRTIF_CTRL_SYNC 2
`define CRTIF_ST_MASTER 0
`define CRTIF_ST_BUSY 1
`define CRTIF_ST_SYNCERR 2
`define CRTIF_ST_PAIRERR 3
`define CRTIF_ST_OVF 4
`define CRTIF_ST_EMPTY 5

// ==========================================================
// Reset values and codes
`define CRTIF_CTRL_RST 2'h0
`define CRTIF_TXEN_RST 8'hff
`define CRTIF_SRC_OSC 2'h0
`define CRTIF_SRC_ECL 2'h1
`define CRTIF_RESP_OK 2'h0
`define CRTIF_RESP_ERR 2'h2

// ==========================================================
// Timing counts
`define CRTIF_WORD_CYC 3'h4
`define CRTIF_SLOT_RX 2'h0
`define CRTIF_SLOT_TX 2'h3
`define CRTIF_STRAP_CYC 2'h2
`define CRTIF_MEM_AW 4
`define CRTIF_NFIBER 8

`endif

/* File: crtif_pkg.sv */
// Types shared by the crate trigger interface files
package crtif_pkg;

	// ==========================================================
	// Link word
	typedef enum logic [1:0] {WT_TIME, WT_CTRL, WT_STROBE, WT_CONTENT} crtif_wtype_t;

	typedef struct packed {
		logic [1:0] spare;
		crtif_wtype_t wtype;
		logic [11:0] payload;
	} crtif_word_t;

	// ==========================================================
	// Merged event record
	typedef struct packed {
		logic [31:0] slot_data;
		logic [19:0] event_num;
		logic [11:0] content;
	} crtif_event_t;

	typedef enum {GEN_IDLE, GEN_CONTENT} crtif_gen_state_t;

endpackage

/* File: crtif_sync2.sv */
// Two flip-flop synchroniser for pin inputs
`timescale 1ns/1ps
module crtif_sync2 #(parameter int W = 1)
(
	input wire logic clk_in,
	input wire logic rst_n_in,
	input wire logic [W-1:0] d_in,
	output logic [W-1:0] q_out
);

	logic [W-1:0] meta;

	// ==========================================================
	// Stages
	always_ff @(posedge clk_in)
	begin
		if (!rst_n_in)
		begin
			meta <= '0;
			q_out <= '0;
		end
		else
		begin
			meta <= d_in;
			q_out <= meta;
		end
	end

endmodule

/* File: crtif_mem.sv */
// Event record memory with registered read port
`timescale 1ns/1ps
`include "crtif_cfg.svh"
module crtif_mem import crtif_pkg::*;
(
	input wire logic clk_in,
	input wire logic we_in,
	input wire logic [`CRTIF_MEM_AW-1:0] waddr_in,
	input wire crtif_event_t wdata_in,
	input wire logic [`CRTIF_MEM_AW-1:0] raddr_in,
	output crtif_event_t rdata_out
);

	crtif_event_t mem [0:(1<<`CRTIF_MEM_AW)-1];

	// ==========================================================
	// Storage
	always_ff @(posedge clk_in)
	begin
		if (we_in)
		begin
			mem[waddr_in] <= wdata_in;
		end
	end

	always_ff @(posedge clk_in)
	begin
		rdata_out <= mem[raddr_in];
	end

endmodule

/* File: crtif_core.sv */
// Crate trigger interface core: link decode, master generator, busy return, event merge
//
// Notes on behaviour
// R01: Link brings clock, trigger words, separate sync.
// R02: One trigger word every four clocks.
// R03: Strobe word drives crate trigger to backplane.
// R04: Backplane busy is OR of front-ends.
// R05: Crate busy forwarded upstream over link.
// R06: Returned status is busy only.
// R07: Oscillator or ECL clock source selects master.
// R08: Master takes front-panel trigger, acts supervisor.
// R09: Master transmits words and sync on fibers.
// R10: Master streams loop back into same decoder.
// R11: Supervisor registers act only in master.
// R12: Master drives up to eight fiber outputs.
// R13: Standard mode selects between two fiber sources.
// R14: Switch-slot link runs on system clock.
// R15: Switch-slot data merged per event.
// R16: Merged events readable over register bus.
// R17: Trigger, clock, sync also on P2.
// R18: Fan-out module returns summed P2 busy.
// R19: Idle frames carry supervisor time bits 13:2.
// R20: Strobes and contents paired in arrival order.
// R21: Upstream busy is backplane OR P2 busy.
`timescale 1ns/1ps
`include "crtif_cfg.svh"
module crtif_core import crtif_pkg::*;
(
	input wire logic CLK_IN,
	input wire logic RST_N_IN,
	input wire logic [7:0] S_AXI_AWADDR_IN,
	input wire logic S_AXI_AWVALID_IN,
	output logic S_AXI_AWREADY_OUT,
	input wire logic [31:0] S_AXI_WDATA_IN,
	input wire logic [3:0] S_AXI_WSTRB_IN,
	input wire logic S_AXI_WVALID_IN,
	output logic S_AXI_WREADY_OUT,
	output logic [1:0] S_AXI_BRESP_OUT,
	output logic S_AXI_BVALID_OUT,
	input wire logic S_AXI_BREADY_IN,
	input wire logic [7:0] S_AXI_ARADDR_IN,
	input wire logic S_AXI_ARVALID_IN,
	output logic S_AXI_ARREADY_OUT,
	output logic [31:0] S_AXI_RDATA_OUT,
	output logic [1:0] S_AXI_RRESP_OUT,
	output logic S_AXI_RVALID_OUT,
	input wire logic S_AXI_RREADY_IN,
	input wire logic [1:0] CLK_SRC_IN,
	input wire logic [15:0] FIBER_A_WORD_IN,
	input wire logic [15:0] FIBER_B_WORD_IN,
	input wire logic FIBER_A_SYNC_IN,
	input wire logic FIBER_B_SYNC_IN,
	input wire logic FP_TRIG_IN,
	input wire logic SD_BUSY_IN,
	input wire logic P2_BUSY_IN,
	input wire logic SS_VALID_IN,
	input wire logic [31:0] SS_DATA_IN,
	output logic SD_TRIG_OUT,
	output logic SD_SYNC_OUT,
	output logic P2_TRIG_OUT,
	output logic P2_SYNC_OUT,
	output logic P2_CLK_OUT,
	output logic UP_BUSY_OUT,
	output logic [15:0] FIBER_TX_WORD_OUT,
	output logic FIBER_TX_SYNC_OUT,
	output logic [`CRTIF_NFIBER-1:0] FIBER_TX_EN_OUT,
	output logic MASTER_MODE_OUT
);

	// ==========================================================
	// Pin synchronisers
	logic [71:0] pin_raw;
	logic [71:0] pin_s;
	logic [1:0] src_s;
	logic [15:0] fa_word;
	logic [15:0] fb_word;
	logic fa_sync, fb_sync, fp_trig, sd_busy, p2_busy, ss_valid;
	logic [31:0] ss_data;

	assign pin_raw = {CLK_SRC_IN, FIBER_A_WORD_IN, FIBER_B_WORD_IN, FIBER_A_SYNC_IN,
		FIBER_B_SYNC_IN, FP_TRIG_IN, SD_BUSY_IN, P2_BUSY_IN, SS_VALID_IN, SS_DATA_IN};

	crtif_sync2 #(.W(72)) u_sync
	(
		.clk_in(CLK_IN),
		.rst_n_in(RST_N_IN),
		.d_in(pin_raw),
		.q_out(pin_s)
	);

	assign src_s = pin_s[71:70];
	assign fa_word = pin_s[69:54];
	assign fb_word = pin_s[53:38];
	assign fa_sync = pin_s[37];
	assign fb_sync = pin_s[36];
	assign fp_trig = pin_s[35];
	assign sd_busy = pin_s[34];
	assign p2_busy = pin_s[33];
	assign ss_valid = pin_s[32];
	assign ss_data = pin_s[31:0];

	// ==========================================================
	// Control state
	logic [1:0] strap_cnt;
	logic src_b, gen_en, sync_req;
	logic [`CRTIF_NFIBER-1:0] tx_en;
	logic [13:0] time_cnt;
	logic sync_prev, fp_prev, strobe_req;
	logic sync_err, pair_err, ovf;
	logic [3:0] pend_cnt;
	logic [19:0] event_num;
	logic [31:0] ss_word;
	logic [`CRTIF_MEM_AW:0] wr_ptr, rd_ptr;
	crtif_gen_state_t gen_state;
	crtif_word_t rx_word;
	crtif_event_t ev_wdata, ev_rdata;
	logic sync_sel, sync_rise, rx_slot, ev_pair, ev_we, mem_full, mem_empty, pop;
	logic [7:0] aw_addr;
	logic [31:0] w_data;
	logic w_lane0, aw_got, w_got, wr_do, rd_do;
	logic [31:0] rd_val;
	logic rd_ok;

	// Strap is only trusted once the synchroniser has filled
	always_ff @(posedge CLK_IN)
	begin
		if (!RST_N_IN)
		begin
			strap_cnt <= 2'h0;
			MASTER_MODE_OUT <= 1'b0;
		end
		else if (strap_cnt != 2'h3)
		begin
			strap_cnt <= strap_cnt + 2'h1;
			if (strap_cnt == `CRTIF_STRAP_CYC)
			begin
				MASTER_MODE_OUT <= (src_s == `CRTIF_SRC_OSC) || (src_s == `CRTIF_SRC_ECL); // [R07]
			end
		end
	end

	// ==========================================================
	// Frame timing and sync
	assign sync_sel = MASTER_MODE_OUT ? FIBER_TX_SYNC_OUT : (src_b ? fb_sync : fa_sync); // [R10] [R13]
	assign sync_rise = sync_sel && !sync_prev;
	assign rx_slot = (time_cnt[1:0] == `CRTIF_SLOT_RX); // [R02]

	always_ff @(posedge CLK_IN)
	begin
		if (!RST_N_IN)
		begin
			sync_prev <= 1'b0;
			time_cnt <= 14'h0;
		end
		else
		begin
			sync_prev <= sync_sel;
			time_cnt <= sync_rise ? 14'h0 : time_cnt + 14'h1; // [R01]
		end
	end

	always_ff @(posedge CLK_IN)
	begin
		if (!RST_N_IN)
		begin
			SD_SYNC_OUT <= 1'b0;
			P2_SYNC_OUT <= 1'b0;
			P2_CLK_OUT <= 1'b0;
		end
		else
		begin
			SD_SYNC_OUT <= sync_rise;
			P2_SYNC_OUT <= sync_rise; // [R17]
			P2_CLK_OUT <= ~P2_CLK_OUT; // [R17]
		end
	end

	// ==========================================================
	// Busy return
	always_ff @(posedge CLK_IN)
	begin
		if (!RST_N_IN)
		begin
			UP_BUSY_OUT <= 1'b0;
		end
		else
		begin
			UP_BUSY_OUT <= sd_busy | p2_busy; // [R04] [R05] [R06] [R18] [R21]
		end
	end

	// ==========================================================
	// Master generator
	always_ff @(posedge CLK_IN)
	begin
		if (!RST_N_IN)
		begin
			fp_prev <= 1'b0;
			strobe_req <= 1'b0;
			gen_state <= GEN_IDLE;
			FIBER_TX_WORD_OUT <= 16'h0;
			FIBER_TX_SYNC_OUT <= 1'b0;
		end
		else
		begin
			fp_prev <= fp_trig;
			FIBER_TX_SYNC_OUT <= 1'b0;
			if (MASTER_MODE_OUT && time_cnt[1:0] == `CRTIF_SLOT_TX)
			begin
				FIBER_TX_SYNC_OUT <= sync_req; // [R09]
				case (gen_state)
					GEN_CONTENT:
					begin
						FIBER_TX_WORD_OUT <= {2'h0, WT_CONTENT, event_num[11:0]};
						gen_state <= GEN_IDLE;
					end
					default:
					begin
						// Busy holds the request back instead of dropping it
						if (strobe_req && gen_en && !UP_BUSY_OUT) // [R08]
						begin
							FIBER_TX_WORD_OUT <= {2'h0, WT_STROBE, event_num[11:0]}; // [R09]
							gen_state <= GEN_CONTENT;
						end
						else
						begin
							FIBER_TX_WORD_OUT <= {2'h0, WT_TIME, time_cnt[13:2] + 12'h1}; // [R19]
						end
					end
				endcase
			end
			if (fp_trig && !fp_prev && MASTER_MODE_OUT)
			begin
				strobe_req <= 1'b1; // [R08]
			end
			else if (time_cnt[1:0] == `CRTIF_SLOT_TX && gen_state == GEN_IDLE && gen_en
				&& !UP_BUSY_OUT)
			begin
				strobe_req <= 1'b0;
			end
		end
	end

	always_ff @(posedge CLK_IN)
	begin
		if (!RST_N_IN)
		begin
			FIBER_TX_EN_OUT <= '0;
		end
		else
		begin
			FIBER_TX_EN_OUT <= MASTER_MODE_OUT ? tx_en : '0; // [R11] [R12]
		end
	end

	// ==========================================================
	// Word decode and pairing
	assign rx_word = MASTER_MODE_OUT ? crtif_word_t'(FIBER_TX_WORD_OUT)
		: crtif_word_t'(src_b ? fb_word : fa_word); // [R10] [R13]
	assign ev_pair = rx_slot && rx_word.wtype == WT_CONTENT && pend_cnt != 4'h0;
	assign ev_we = ev_pair && !mem_full;

	always_ff @(posedge CLK_IN)
	begin
		if (!RST_N_IN)
		begin
			SD_TRIG_OUT <= 1'b0;
			P2_TRIG_OUT <= 1'b0;
			pend_cnt <= 4'h0;
		end
		else
		begin
			SD_TRIG_OUT <= rx_slot && rx_word.wtype == WT_STROBE; // [R03]
			P2_TRIG_OUT <= rx_slot && rx_word.wtype == WT_STROBE; // [R17]
			if (rx_slot && rx_word.wtype == WT_STROBE && pend_cnt != 4'hf)
			begin
				pend_cnt <= pend_cnt + 4'h1; // [R20]
			end
			else if (ev_pair)
			begin
				pend_cnt <= pend_cnt - 4'h1; // [R20]
			end
		end
	end

	// Error flags: a new event wins over a software clear
	always_ff @(posedge CLK_IN)
	begin
		if (!RST_N_IN)
		begin
			sync_err <= 1'b0;
			pair_err <= 1'b0;
			ovf <= 1'b0;
		end
		else
		begin
			if (rx_slot && rx_word.wtype == WT_TIME && rx_word.payload != time_cnt[13:2])
				sync_err <= 1'b1; // [R19]
			else if (wr_do && aw_addr == `CRTIF_A_STAT && w_lane0 && w_data[`CRTIF_ST_SYNCERR])
				sync_err <= 1'b0;
			if (rx_slot && ((rx_word.wtype == WT_CONTENT && pend_cnt == 4'h0)
				|| (rx_word.wtype == WT_STROBE && pend_cnt == 4'hf)))
				pair_err <= 1'b1; // [R20]
			else if (wr_do && aw_addr == `CRTIF_A_STAT && w_lane0 && w_data[`CRTIF_ST_PAIRERR])
				pair_err <= 1'b0;
			if (ev_pair && mem_full)
				ovf <= 1'b1;
			else if (wr_do && aw_addr == `CRTIF_A_STAT && w_lane0 && w_data[`CRTIF_ST_OVF])
				ovf <= 1'b0;
		end
	end

	// ==========================================================
	// Event merge
	assign mem_full = (wr_ptr[`CRTIF_MEM_AW] != rd_ptr[`CRTIF_MEM_AW])
		&& (wr_ptr[`CRTIF_MEM_AW-1:0] == rd_ptr[`CRTIF_MEM_AW-1:0]);
	assign mem_empty = (wr_ptr == rd_ptr);
	assign pop = rd_do && S_AXI_ARADDR_IN == `CRTIF_A_EVLO && !mem_empty; // [R16]
	assign ev_wdata = '{slot_data: ss_word, event_num: event_num, content: rx_word.payload};

	always_ff @(posedge CLK_IN)
	begin
		if (!RST_N_IN)
		begin
			ss_word <= 32'h0;
			event_num <= 20'h0;
			wr_ptr <= '0;
			rd_ptr <= '0;
		end
		else
		begin
			if (ev_pair)
			begin
				ss_word <= 32'h0; // [R15]
				event_num <= event_num + 20'h1;
			end
			else if (ss_valid)
			begin
				ss_word <= ss_data; // [R14]
			end
			if (ev_we)
				wr_ptr <= wr_ptr + 1'b1; // [R15]
			if (pop)
				rd_ptr <= rd_ptr + 1'b1;
		end
	end

	crtif_mem u_mem
	(
		.clk_in(CLK_IN),
		.we_in(ev_we),
		.waddr_in(wr_ptr[`CRTIF_MEM_AW-1:0]),
		.wdata_in(ev_wdata),
		.raddr_in(rd_ptr[`CRTIF_MEM_AW-1:0]),
		.rdata_out(ev_rdata)
	);

	// ==========================================================
	// Register bus write side
	assign wr_do = aw_got && w_got && !S_AXI_BVALID_OUT;

	always_ff @(posedge CLK_IN)
	begin
		if (!RST_N_IN)
		begin
			S_AXI_AWREADY_OUT <= 1'b1;
			S_AXI_WREADY_OUT <= 1'b1;
			aw_got <= 1'b0;
			w_got <= 1'b0;
			aw_addr <= 8'h0;
			w_data <= 32'h0;
			w_lane0 <= 1'b0;
			S_AXI_BVALID_OUT <= 1'b0;
			S_AXI_BRESP_OUT <= `CRTIF_RESP_OK;
		end
		else
		begin
			if (S_AXI_AWVALID_IN && S_AXI_AWREADY_OUT)
			begin
				aw_addr <= S_AXI_AWADDR_IN;
				aw_got <= 1'b1;
				S_AXI_AWREADY_OUT <= 1'b0;
			end
			if (S_AXI_WVALID_IN && S_AXI_WREADY_OUT)
			begin
				w_data <= S_AXI_WSTRB_IN[0] ? S_AXI_WDATA_IN : 32'h0;
				// Strobe kept with the data, the master may drop it once taken
				w_lane0 <= S_AXI_WSTRB_IN[0];
				w_got <= 1'b1;
				S_AXI_WREADY_OUT <= 1'b0;
			end
			if (wr_do)
			begin
				aw_got <= 1'b0;
				w_got <= 1'b0;
				S_AXI_BVALID_OUT <= 1'b1;
				S_AXI_BRESP_OUT <= (aw_addr <= `CRTIF_A_EVCNT && aw_addr[1:0] == 2'h0)
					? `CRTIF_RESP_OK : `CRTIF_RESP_ERR;
			end
			if (S_AXI_BVALID_OUT && S_AXI_BREADY_IN)
			begin
				S_AXI_BVALID_OUT <= 1'b0;
				S_AXI_AWREADY_OUT <= 1'b1;
				S_AXI_WREADY_OUT <= 1'b1;
			end
		end
	end

	always_ff @(posedge CLK_IN)
	begin
		if (!RST_N_IN)
		begin
			{gen_en, src_b} <= `CRTIF_CTRL_RST;
			tx_en <= `CRTIF_TXEN_RST;
			sync_req <= 1'b0;
		end
		else
		begin
			if (wr_do && aw_addr == `CRTIF_A_CTRL)
			begin
				src_b <= w_data[`CRTIF_CTRL_SRCB]; // [R13]
				gen_en <= w_data[`CRTIF_CTRL_GEN]; // [R11]
			end
			if (wr_do && aw_addr == `CRTIF_A_TXEN)
				tx_en <= w_data[`CRTIF_NFIBER-1:0]; // [R12]
			if (wr_do && aw_addr == `CRTIF_A_CTRL && w_data[`CRTIF_CTRL_SYNC])
				sync_req <= 1'b1;
			else if (time_cnt[1:0] == `CRTIF_SLOT_TX)
				sync_req <= 1'b0;
		end
	end

	// ==========================================================
	// Register bus read side
	always_comb
	begin
		rd_ok = 1'b1;
		rd_val = 32'h0;
		case (S_AXI_ARADDR_IN)
			`CRTIF_A_CTRL: rd_val = {30'h0, gen_en, src_b};
			`CRTIF_A_TXEN: rd_val = {24'h0, tx_en};
			`CRTIF_A_STAT: rd_val = {20'h0, pend_cnt, 2'h0, mem_empty, ovf, pair_err, sync_err,
				UP_BUSY_OUT, MASTER_MODE_OUT};
			`CRTIF_A_TIME: rd_val = {18'h0, time_cnt};
			`CRTIF_A_EVHI: rd_val = ev_rdata[63:32];
			`CRTIF_A_EVLO: rd_val = ev_rdata[31:0];
			`CRTIF_A_EVCNT: rd_val = {27'h0, wr_ptr - rd_ptr};
			default: rd_ok = 1'b0;
		endcase
	end

	assign rd_do = S_AXI_ARVALID_IN && S_AXI_ARREADY_OUT;

	always_ff @(posedge CLK_IN)
	begin
		if (!RST_N_IN)
		begin
			S_AXI_ARREADY_OUT <= 1'b1;
			S_AXI_RVALID_OUT <= 1'b0;
			S_AXI_RDATA_OUT <= 32'h0;
			S_AXI_RRESP_OUT <= `CRTIF_RESP_OK;
		end
		else if (rd_do)
		begin
			S_AXI_ARREADY_OUT <= 1'b0;
			S_AXI_RVALID_OUT <= 1'b1;
			S_AXI_RDATA_OUT <= rd_val; // [R16]
			S_AXI_RRESP_OUT <= rd_ok ? `CRTIF_RESP_OK : `CRTIF_RESP_ERR;
		end
		else if (S_AXI_RVALID_OUT && S_AXI_RREADY_IN)
		begin
			S_AXI_RVALID_OUT <= 1'b0;
			S_AXI_ARREADY_OUT <= 1'b1;
		end
	end

endmodule

/* File: crtif_properties.sv */
// Concurrent checks on the crate trigger interface core ports
`timescale 1ns/1ps
module crtif_properties import crtif_pkg::*;
(
	input wire logic CLK_IN,
	input wire logic RST_N_IN,
	input wire logic S_AXI_AWREADY_OUT,
	input wire logic S_AXI_WREADY_OUT,
	input wire logic S_AXI_BVALID_OUT,
	input wire logic S_AXI_BREADY_IN,
	input wire logic S_AXI_ARVALID_IN,
	input wire logic S_AXI_ARREADY_OUT,
	input wire logic S_AXI_RVALID_OUT,
	input wire logic [1:0] CLK_SRC_IN,
	input wire logic SD_BUSY_IN,
	input wire logic P2_BUSY_IN,
	input wire logic SD_TRIG_OUT,
	input wire logic SD_SYNC_OUT,
	input wire logic P2_TRIG_OUT,
	input wire logic P2_SYNC_OUT,
	input wire logic P2_CLK_OUT,
	input wire logic UP_BUSY_OUT,
	input wire logic [15:0] FIBER_TX_WORD_OUT,
	input wire logic [7:0] FIBER_TX_EN_OUT,
	input wire logic MASTER_MODE_OUT
);
	// ==========
	// Edges since release, so delayed paths are judged only once filled
	logic [2:0] up_cnt;
	logic busy_or;
	logic tx_strobe;
	assign busy_or = SD_BUSY_IN | P2_BUSY_IN;
	assign tx_strobe = FIBER_TX_WORD_OUT[13:12] == WT_STROBE;
	always_ff @(posedge CLK_IN)
	begin
		if (!RST_N_IN)
			up_cnt <= 3'h0;
		else if (up_cnt != 3'h7)
			up_cnt <= up_cnt + 3'h1;
	end
	default clocking cb @(posedge CLK_IN);
	endclocking
	default disable iff (!RST_N_IN);
	// ==========
	// Properties
	property p_busy; up_cnt > 3'h3 |-> UP_BUSY_OUT == $past(busy_or, 3); endproperty
	a_busy: assert property (p_busy) else $error("upstream busy wrong");
	property p_mode; up_cnt > 3'h4 |-> MASTER_MODE_OUT == (CLK_SRC_IN < 2'h2); endproperty
	a_mode: assert property (p_mode) else $error("mode flag wrong");
	property p_trig_gap; SD_TRIG_OUT |=> !SD_TRIG_OUT [*3]; endproperty
	a_trig_gap: assert property (p_trig_gap) else $error("trigger spacing");
	property p_trig_p2; SD_TRIG_OUT == P2_TRIG_OUT; endproperty
	a_trig_p2: assert property (p_trig_p2) else $error("p2 trigger differs");
	property p_sync_p2; SD_SYNC_OUT == P2_SYNC_OUT; endproperty
	a_sync_p2: assert property (p_sync_p2) else $error("p2 sync differs");
	property p_p2clk; up_cnt > 3'h3 |-> P2_CLK_OUT != $past(P2_CLK_OUT); endproperty
	a_p2clk: assert property (p_p2clk) else $error("p2 clock stuck");
	property p_quiet; !MASTER_MODE_OUT |-> FIBER_TX_EN_OUT == 8'h00; endproperty
	a_quiet: assert property (p_quiet) else $error("fiber tx in standard");
	property p_loop; MASTER_MODE_OUT && SD_TRIG_OUT |-> $past(tx_strobe); endproperty
	a_loop: assert property (p_loop) else $error("loopback trigger");
	property p_b_hold; S_AXI_BVALID_OUT && !S_AXI_BREADY_IN |=> S_AXI_BVALID_OUT; endproperty
	a_b_hold: assert property (p_b_hold) else $error("bvalid dropped");
	property p_r_lat; S_AXI_ARVALID_IN && S_AXI_ARREADY_OUT |=> S_AXI_RVALID_OUT; endproperty
	a_r_lat: assert property (p_r_lat) else $error("read answer late");
	property p_w_blk; S_AXI_BVALID_OUT |-> !S_AXI_AWREADY_OUT && !S_AXI_WREADY_OUT; endproperty
	a_w_blk: assert property (p_w_blk) else $error("write taken early");
	c_std: cover property (SD_TRIG_OUT && !MASTER_MODE_OUT);
	c_mst: cover property (SD_TRIG_OUT && MASTER_MODE_OUT);
	c_busy: cover property ($rose(UP_BUSY_OUT));
endmodule

/* File: crtif_upstream_model.sv */
// Upstream distribution board model feeding one fiber input
`timescale 1ns/1ps
module crtif_upstream_model import crtif_pkg::*;
(
	input wire logic clk_in,
	input wire logic rst_n_in,
	input wire logic trig_in,
	input wire logic [11:0] content_in,
	input wire logic busy_in,
	output logic [15:0] word_out,
	output logic sync_out
);
	// ==========
	// Supervisor time, pending strobes, queued contents
	logic [13:0] t;
	int pend;
	logic [11:0] cq[$];
	always @(posedge clk_in)
	begin
		if (!rst_n_in)
		begin
			t <= 14'h0000;
			pend = 0;
			cq.delete();
			word_out <= 16'h0000;
			sync_out <= 1'b0;
		end
		else
		begin
			t <= t + 14'h0001;
			sync_out <= t[13:2] == 12'h001;
			if (trig_in)
			begin
				pend++;
				cq.push_back(content_in);
			end
			// Word held four clocks
			if (t[1:0] == 2'h3)
			begin
				// Strobes wait while crate is busy
				if (pend > 0 && !busy_in)
				begin
					word_out <= {2'b00, WT_STROBE, 12'h000};
					pend--;
				end
				else if (cq.size() > 0 && pend == 0)
					word_out <= {2'b00, WT_CONTENT, cq.pop_front()};
				else
					word_out <= {2'b00, WT_TIME, t[13:2]};
			end
		end
	end
endmodule

/* File: crate_trigger_interface_core_tb.sv */
// Self-checking bench for the crate trigger interface core
`timescale 1ns/1ps
`include "crtif_cfg.svh"
module crate_trigger_interface_core_tb;
	// ==========
	// Signals
	logic CLK_IN = 1'b0;
	logic RST_N_IN = 1'b0;
	logic [7:0] S_AXI_AWADDR_IN = 8'h00, S_AXI_ARADDR_IN = 8'h00;
	logic [31:0] S_AXI_WDATA_IN = 32'h0, SS_DATA_IN = 32'h0, S_AXI_RDATA_OUT, d;
	logic [3:0] S_AXI_WSTRB_IN = 4'hf;
	logic S_AXI_AWVALID_IN = 1'b0, S_AXI_WVALID_IN = 1'b0, S_AXI_BREADY_IN = 1'b0;
	logic S_AXI_ARVALID_IN = 1'b0, S_AXI_RREADY_IN = 1'b0, SS_VALID_IN = 1'b0;
	logic [1:0] CLK_SRC_IN = 2'h3, S_AXI_BRESP_OUT, S_AXI_RRESP_OUT, r;
	logic FP_TRIG_IN = 1'b0, SD_BUSY_IN = 1'b0, P2_BUSY_IN = 1'b0, trig_a = 1'b0, trig_b = 1'b0;
	logic [15:0] FIBER_A_WORD_IN, FIBER_B_WORD_IN, FIBER_TX_WORD_OUT;
	logic FIBER_A_SYNC_IN, FIBER_B_SYNC_IN, S_AXI_AWREADY_OUT, S_AXI_WREADY_OUT;
	logic S_AXI_BVALID_OUT, S_AXI_ARREADY_OUT, S_AXI_RVALID_OUT, SD_TRIG_OUT, SD_SYNC_OUT;
	logic P2_TRIG_OUT, P2_SYNC_OUT, P2_CLK_OUT, UP_BUSY_OUT, FIBER_TX_SYNC_OUT, MASTER_MODE_OUT;
	logic [7:0] FIBER_TX_EN_OUT;
	logic [11:0] cont = 12'h000;
	logic [11:0] cq[$];
	logic [31:0] sq[$];
	logic [19:0] ev0;
	int err_count = 0, n_checks = 0, cyc = 0, trig_n = 0, sync_n = 0, txs_n = 0, txw_n = 0;

	crtif_core DUT (.*);
	crtif_upstream_model up_a (.clk_in(CLK_IN), .rst_n_in(RST_N_IN), .trig_in(trig_a),
		.content_in(cont), .busy_in(UP_BUSY_OUT), .word_out(FIBER_A_WORD_IN),
		.sync_out(FIBER_A_SYNC_IN));
	crtif_upstream_model up_b (.clk_in(CLK_IN), .rst_n_in(RST_N_IN), .trig_in(trig_b),
		.content_in(cont), .busy_in(UP_BUSY_OUT), .word_out(FIBER_B_WORD_IN),
		.sync_out(FIBER_B_SYNC_IN));

	always #25 CLK_IN = ~CLK_IN;

	// ==========
	// Monitors and hang guard
	always @(posedge CLK_IN)
	begin
		cyc++;
		trig_n += SD_TRIG_OUT === 1'b1;
		sync_n += SD_SYNC_OUT === 1'b1;
		txs_n += FIBER_TX_SYNC_OUT === 1'b1;
		txw_n += FIBER_TX_WORD_OUT[13:12] === 2'h2;
		if (cyc == 5000)
		begin
			err_count++;
			tally_and_finish();
		end
	end

	// ==========
	// Tasks
	task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
		n_checks++;
		if (seen !== exp)
		begin
			err_count++;
			$display("CHECK FAILED t=%0t seen=%h exp=%h", $time, seen, exp);
		end
	endtask

	task automatic tally_and_finish();
		$display("checks %0d errors %0d", n_checks, err_count);
		if (err_count == 0 && n_checks > 0)
			$display("bench passed");
		else
			$display("bench failed");
		$finish;
	endtask

	task automatic do_reset(input logic [1:0] src);
		@(posedge CLK_IN);
		RST_N_IN <= 1'b0;
		CLK_SRC_IN <= src;
		repeat (20) @(posedge CLK_IN);
		RST_N_IN <= 1'b1;
		repeat (6) @(posedge CLK_IN);
		trig_n = 0;
		sync_n = 0;
		txw_n = 0;
	endtask

	task automatic axw(input logic [7:0] a, input logic [31:0] v, output logic [1:0] rr);
		@(posedge CLK_IN);
		S_AXI_AWADDR_IN <= a;
		S_AXI_AWVALID_IN <= 1'b1;
		S_AXI_WDATA_IN <= v;
		S_AXI_WVALID_IN <= 1'b1;
		S_AXI_BREADY_IN <= 1'b1;
		do
		begin
			@(posedge CLK_IN);
			if (S_AXI_AWREADY_OUT) S_AXI_AWVALID_IN <= 1'b0;
			if (S_AXI_WREADY_OUT) S_AXI_WVALID_IN <= 1'b0;
		end
		while (S_AXI_BVALID_OUT !== 1'b1);
		rr = S_AXI_BRESP_OUT;
		S_AXI_BREADY_IN <= 1'b0;
	endtask

	task automatic axr(input logic [7:0] a, output logic [31:0] v, output logic [1:0] rr);
		@(posedge CLK_IN);
		S_AXI_ARADDR_IN <= a;
		S_AXI_ARVALID_IN <= 1'b1;
		S_AXI_RREADY_IN <= 1'b1;
		do
		begin
			@(posedge CLK_IN);
			if (S_AXI_ARREADY_OUT) S_AXI_ARVALID_IN <= 1'b0;
		end
		while (S_AXI_RVALID_OUT !== 1'b1);
		v = S_AXI_RDATA_OUT;
		rr = S_AXI_RRESP_OUT;
		S_AXI_RREADY_IN <= 1'b0;
	endtask

	// Switch-slot word (or none), then one trigger on fiber A or B
	task automatic fire(input logic b, input logic ss);
		logic [31:0] w;
		logic [11:0] c;
		w = ss ? $urandom : 32'h0;
		c = 12'($urandom);
		@(posedge CLK_IN);
		SS_VALID_IN <= ss;
		SS_DATA_IN <= w;
		@(posedge CLK_IN);
		SS_VALID_IN <= 1'b0;
		cont <= c;
		trig_a <= !b;
		trig_b <= b;
		@(posedge CLK_IN);
		trig_a <= 1'b0;
		trig_b <= 1'b0;
		sq.push_back(w);
		cq.push_back(c);
	endtask

	// ==========
	// Sequence
	initial
	begin
		d = $urandom(32'h7c94);
		for (int s = 0; s < 4; s++)
		begin
			do_reset(2'(s));
			chk(MASTER_MODE_OUT, s < 2);
			axr(`CRTIF_A_STAT, d, r);
			chk(d[0], s < 2);
		end
		axr(8'h1c, d, r);
		chk({d, r}, {32'h0, `CRTIF_RESP_ERR});
		axw(8'h1c, 32'h1, r);
		chk(r, `CRTIF_RESP_ERR);
		axr(`CRTIF_A_TXEN, d, r);
		chk(d[7:0], `CRTIF_TXEN_RST);
		chk(sync_n != 0, 1'b1);
		for (int k = 0; k < 4; k++)
		begin
			fire(1'b0, !k[0]);
			if (k[0]) repeat (40) @(posedge CLK_IN);
		end
		chk(trig_n, 4);
		axr(`CRTIF_A_EVCNT, d, r);
		chk(d, 32'h4);
		for (int k = 0; k < 4; k++)
		begin
			axr(`CRTIF_A_EVHI, d, r);
			chk(d, sq[k]);
			axr(`CRTIF_A_EVLO, d, r);
			chk(d[11:0], cq[k]);
			if (k == 0) ev0 = d[31:12];
			chk(d[31:12], 20'(ev0 + k));
		end
		axw(`CRTIF_A_CTRL, 32'h1, r);
		fire(1'b1, 1'b0);
		fire(1'b0, 1'b0);
		repeat (40) @(posedge CLK_IN);
		chk(trig_n, 5);
		for (int k = 0; k < 24; k++)
		begin
			@(posedge CLK_IN);
			SD_BUSY_IN <= 1'($urandom);
			P2_BUSY_IN <= 1'($urandom);
			repeat (4) @(posedge CLK_IN);
			chk(UP_BUSY_OUT, SD_BUSY_IN | P2_BUSY_IN);
		end
		SD_BUSY_IN <= 1'b0;
		P2_BUSY_IN <= 1'b0;
		do_reset(2'h0);
		axw(`CRTIF_A_CTRL, 32'h2, r);
		axw(`CRTIF_A_TXEN, 32'h5a, r);
		@(posedge CLK_IN);
		chk(FIBER_TX_EN_OUT, 8'h5a);
		@(posedge CLK_IN);
		FP_TRIG_IN <= 1'b1;
		repeat (2) @(posedge CLK_IN);
		FP_TRIG_IN <= 1'b0;
		repeat (40) @(posedge CLK_IN);
		chk(trig_n, 1);
		chk(txw_n != 0, 1'b1);
		axr(`CRTIF_A_EVCNT, d, r);
		chk(d, 32'h1);
		sync_n = 0;
		txs_n = 0;
		axw(`CRTIF_A_CTRL, 32'h6, r);
		repeat (20) @(posedge CLK_IN);
		chk({txs_n != 0, sync_n != 0}, 2'h3);
		tally_and_finish();
	end
endmodule

bind crtif_core crtif_properties u_props (.*);
